/* common/opa_params.svh */
/*
 Constants for the integer outer-product accumulate datapath.
 Assumes it is included by bare name from the package and design files.
*/
`ifndef OPA_PARAMS_SVH
`define OPA_PARAMS_SVH

// Streaming vector length in bits
`define OPA_VL_BITS 128
// Element and accumulator widths of the two variants
`define OPA_NARROW_IN_W 8
`define OPA_NARROW_ACC_W 32
`define OPA_WIDE_IN_W 16
`define OPA_WIDE_ACC_W 64
// Sub-elements folded into one destination element
`define OPA_DOT_WAYS 4
// Number of selectable destination tiles
`define OPA_NARROW_TILES 4
`define OPA_WIDE_TILES 8
// Vector bits governed by one predicate bit
`define OPA_PRED_PER_BYTE 8
// Tile field width
`define OPA_TILE_FIELD_W 3
// Condition flag width
`define OPA_FLAGS_W 4

`endif

/* common/opa_pkg.sv */
/*
 Types shared by the outer-product datapath files.
 Assumes opa_params.svh is on the include path.
*/
`include "opa_params.svh"

package opa_pkg;

    // Operation selected by the pipeline
    typedef enum logic [1:0] {
        mixed_sign_outer_acc,
        mixed_sign_outer_sub,
        unsigned_outer_acc,
        unsigned_outer_sub
    } op_kind_t;

    // Sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } seq_state_t;

endpackage

/* hw/dot4_lane.sv */
/*
 One 4-way dot product lane, purely combinational.
 Assumes the caller presents containers in the low bits and gated activity bits.
*/
`timescale 1ns/1ns
`include "opa_params.svh"

module dot4_lane
    import opa_pkg::*;
(
    input wire logic [`OPA_WIDE_ACC_W-1:0] a_in,
    input wire logic [`OPA_WIDE_ACC_W-1:0] b_in,
    input wire logic [`OPA_DOT_WAYS-1:0] a_act_in,
    input wire logic [`OPA_DOT_WAYS-1:0] b_act_in,
    input wire logic wide_in,
    input wire logic a_signed_in,
    output logic [`OPA_WIDE_ACC_W-1:0] sum_out
);

    // Widen one sub-element to 17 bits; second source is always unsigned
    function automatic logic signed [`OPA_WIDE_IN_W:0] widen(
        input logic [`OPA_WIDE_IN_W-1:0] v,
        input logic wide,
        input logic sgn
    );
        logic signed [`OPA_WIDE_IN_W:0] r;
        if (wide) begin
            r = {sgn & v[`OPA_WIDE_IN_W-1], v};
        end else begin
            r = {{(`OPA_WIDE_IN_W-`OPA_NARROW_IN_W+1){sgn & v[`OPA_NARROW_IN_W-1]}},
                 v[`OPA_NARROW_IN_W-1:0]};
        end
        return r;
    endfunction

    // Sum four products; inactive pairs are skipped, so data never alters timing
    always_comb begin
        logic signed [`OPA_WIDE_IN_W:0] ea;
        logic signed [`OPA_WIDE_IN_W:0] eb;
        logic signed [2*`OPA_WIDE_IN_W+1:0] prod;
        logic [`OPA_WIDE_ACC_W-1:0] acc;
        ea = '0;
        eb = '0;
        prod = '0;
        acc = '0;
        for (int k = 0; k < `OPA_DOT_WAYS; k++) begin
            if (wide_in) begin
                ea = widen(a_in[`OPA_WIDE_IN_W*k +: `OPA_WIDE_IN_W], 1'b1, a_signed_in); // [RULE3]
                eb = widen(b_in[`OPA_WIDE_IN_W*k +: `OPA_WIDE_IN_W], 1'b1, 1'b0); // [RULE4]
            end else begin
                ea = widen({8'h00, a_in[`OPA_NARROW_IN_W*k +: `OPA_NARROW_IN_W]}, 1'b0,
                           a_signed_in); // [RULE17]
                eb = widen({8'h00, b_in[`OPA_NARROW_IN_W*k +: `OPA_NARROW_IN_W]}, 1'b0, 1'b0);
            end
            prod = ea * eb;
            if (a_act_in[k] && b_act_in[k]) begin // [RULE6]
                acc = acc + {{(`OPA_WIDE_ACC_W-2*`OPA_WIDE_IN_W-2){prod[2*`OPA_WIDE_IN_W+1]}},
                             prod}; // [RULE9]
            end
        end
        sum_out = acc;
    end

endmodule

/* hw/int_outer_product_accumulate.sv */
/*
 Integer outer-product accumulate datapath with its own tile storage.
 Assumes the pipeline holds operands stable while OP_VALID_IN is high and
 OP_READY_OUT is high, and that all inputs are synchronous to MCLK_IN.
*/
// What this block does
// [RULE1] Narrow variant: 8-bit sources accumulate into 32-bit tile elements.
// [RULE2] Wide variant: 16-bit sources accumulate into 64-bit tile elements.
// [RULE3] Mixed-sign subtract: first source signed, second source unsigned.
// [RULE4] Unsigned accumulate: both sources read as unsigned.
// [RULE5] Each source is masked by its own predicate, independently.
// [RULE6] Inactive source elements contribute zero to the sum.
// [RULE7] Subtract kinds take the widened sum from every destination element.
// [RULE8] Accumulate kinds add the widened sum to every destination element.
// [RULE9] Each destination element gets a 4-way dot product of paired sub-elements.
// [RULE10] First-source container holds four column elements of one row.
// [RULE11] Second-source container holds four row elements of one column.
// [RULE12] Narrow selects one of four tiles, wide one of eight.
// [RULE13] Wide variant needs the feature bit, else the operation is undefined.
// [RULE14] Latency never depends on operand data values.
// [RULE15] Latency and exception handling ignore the condition flags.
// [RULE16] Exception response does not depend on operand data.
// [RULE17] Mixed-sign accumulate also exists: signed by unsigned, then add.
// [RULE18] Accumulation wraps at element width, no saturation or flag.
// [RULE19] Runs only with streaming mode and tile storage on, else traps.
`timescale 1ns/1ns
`include "opa_params.svh"

module int_outer_product_accumulate
    import opa_pkg::*;
#(
    parameter int VL_BITS = `OPA_VL_BITS,
    parameter int WORD_ELEMS = `OPA_VL_BITS / `OPA_NARROW_ACC_W,
    parameter int DWORD_ELEMS = `OPA_VL_BITS / `OPA_WIDE_ACC_W,
    parameter int STORE_WORDS = `OPA_NARROW_TILES * WORD_ELEMS * WORD_ELEMS,
    parameter int ADDR_W = $clog2(STORE_WORDS)
)
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic OP_VALID_IN,
    output logic OP_READY_OUT,
    input wire op_kind_t OP_KIND_IN,
    input wire logic OP_WIDE_IN,
    input wire logic [`OPA_TILE_FIELD_W-1:0] DEST_TILE_FIELD_IN,
    input wire logic [VL_BITS-1:0] FIRST_VECTOR_IN,
    input wire logic [VL_BITS-1:0] SECOND_VECTOR_IN,
    input wire logic [VL_BITS/`OPA_PRED_PER_BYTE-1:0] FIRST_PREDICATE_IN,
    input wire logic [VL_BITS/`OPA_PRED_PER_BYTE-1:0] SECOND_PREDICATE_IN,
    input wire logic [`OPA_FLAGS_W-1:0] CONDITION_FLAGS_IN,
    input wire logic STREAMING_EN_IN,
    input wire logic STORAGE_EN_IN,
    input wire logic WIDE_INT_VARIANT_PRESENT_IN,
    input wire logic [ADDR_W-1:0] RD_ADDR_IN,
    output logic [`OPA_NARROW_ACC_W-1:0] RD_DATA_OUT,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic TRAP_OUT,
    output logic UNDEF_OUT
);

    localparam int PRED_W = VL_BITS / `OPA_PRED_PER_BYTE;
    localparam int ROW_W = $clog2(WORD_ELEMS) + 1;
    localparam int NW = `OPA_NARROW_ACC_W;
    localparam int WW = `OPA_WIDE_ACC_W;

    // Tile storage, narrow words; a wide element spans two adjacent words
    logic [NW-1:0] store_q [STORE_WORDS];

    seq_state_t state_q;
    seq_state_t state_d;
    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] row_limit;
    logic [VL_BITS-1:0] first_vec_q;
    logic [VL_BITS-1:0] second_vec_q;
    logic [PRED_W-1:0] first_pred_q;
    logic [PRED_W-1:0] second_pred_q;
    op_kind_t kind_q;
    logic wide_q;
    logic [`OPA_TILE_FIELD_W-1:0] tile_q;
    logic done_q;
    logic trap_q;
    logic undef_q;
    logic [NW-1:0] rd_data_q;

    logic accept;
    logic legal;
    logic enabled;
    logic last_row;
    logic a_signed;
    logic sub_op;
    logic [WW-1:0] row_cont;
    logic [`OPA_DOT_WAYS-1:0] row_act;

    // Pick one source container for row or column idx; narrow is zero-padded
    function automatic logic [WW-1:0] pick_cont(
        input logic [VL_BITS-1:0] v,
        input int idx,
        input logic wide
    );
        logic [WW-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_ELEMS; i++) begin
            if (!wide && i == idx) begin
                r = {{(WW-NW){1'b0}}, v[NW*i +: NW]}; // [RULE10]
            end
        end
        for (int i = 0; i < DWORD_ELEMS; i++) begin
            if (wide && i == idx) begin
                r = v[WW*i +: WW]; // [RULE10]
            end
        end
        return r;
    endfunction

    // Predicate bits of the four sub-elements of container idx
    function automatic logic [`OPA_DOT_WAYS-1:0] pick_act(
        input logic [PRED_W-1:0] p,
        input int idx,
        input logic wide
    );
        logic [`OPA_DOT_WAYS-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_ELEMS; i++) begin
            if (!wide && i == idx) begin
                r = p[`OPA_DOT_WAYS*i +: `OPA_DOT_WAYS];
            end
        end
        for (int i = 0; i < DWORD_ELEMS; i++) begin
            if (wide && i == idx) begin
                // One predicate bit per byte: a 16-bit element uses its low byte's bit
                for (int k = 0; k < `OPA_DOT_WAYS; k++) begin
                    r[k] = p[2*`OPA_DOT_WAYS*i + 2*k];
                end
            end
        end
        return r;
    endfunction

    // Operation decode: first-source signedness and direction
    always_comb begin
        a_signed = 1'b0;
        sub_op = 1'b0;
        case (kind_q)
            mixed_sign_outer_acc: begin
                a_signed = 1'b1; // [RULE17]
                sub_op = 1'b0;
            end
            mixed_sign_outer_sub: begin
                a_signed = 1'b1; // [RULE3]
                sub_op = 1'b1;
            end
            unsigned_outer_acc: begin
                a_signed = 1'b0; // [RULE4]
                sub_op = 1'b0;
            end
            unsigned_outer_sub: begin
                a_signed = 1'b0;
                sub_op = 1'b1;
            end
            default: begin
                a_signed = 1'b0;
                sub_op = 1'b0;
            end
        endcase
    end

    // Admission checks; flags are deliberately not looked at
    assign enabled = STREAMING_EN_IN && STORAGE_EN_IN; // [RULE19]
    assign legal = enabled && !(OP_WIDE_IN && !WIDE_INT_VARIANT_PRESENT_IN); // [RULE13]
    assign OP_READY_OUT = (state_q == ST_IDLE);
    assign accept = OP_VALID_IN && OP_READY_OUT && legal; // [RULE15]

    // Row count is fixed per variant, so latency is data-independent
    assign row_limit = wide_q ? ROW_W'(DWORD_ELEMS) : ROW_W'(WORD_ELEMS); // [RULE14]
    assign last_row = (row_q == row_limit - ROW_W'(1));

    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (last_row) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Row walk, one tile row per cycle
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            row_q <= '0;
        end else if (accept) begin
            row_q <= '0;
        end else if (state_q == ST_RUN) begin
            row_q <= last_row ? '0 : row_q + ROW_W'(1);
        end
    end

    // Operand capture; the pipeline may move on once accepted
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            first_vec_q <= '0;
            second_vec_q <= '0;
            first_pred_q <= '0;
            second_pred_q <= '0;
            kind_q <= unsigned_outer_acc;
            wide_q <= 1'b0;
            tile_q <= '0;
        end else if (accept) begin
            first_vec_q <= FIRST_VECTOR_IN;
            second_vec_q <= SECOND_VECTOR_IN;
            first_pred_q <= FIRST_PREDICATE_IN;
            second_pred_q <= SECOND_PREDICATE_IN;
            kind_q <= OP_KIND_IN;
            wide_q <= OP_WIDE_IN;
            // Narrow tiles use only the low two bits of the field
            tile_q <= OP_WIDE_IN ? DEST_TILE_FIELD_IN
                                 : {1'b0, DEST_TILE_FIELD_IN[1:0]}; // [RULE12]
        end
    end

    // Shared row operand and its first-predicate mask
    assign row_cont = pick_cont(first_vec_q, int'(row_q), wide_q);
    assign row_act = pick_act(first_pred_q, int'(row_q), wide_q); // [RULE5]

    // Per-column lanes and write-back values
    logic [WW-1:0] lane_sum [WORD_ELEMS];
    logic [ADDR_W-1:0] lane_addr [WORD_ELEMS];
    logic [WW-1:0] lane_new [WORD_ELEMS];
    logic lane_wr [WORD_ELEMS];

    genvar gc;
    generate
        for (gc = 0; gc < WORD_ELEMS; gc++) begin : g_col
            logic [WW-1:0] col_cont;
            logic [`OPA_DOT_WAYS-1:0] col_act;
            logic [WW-1:0] old_val;

            assign col_cont = pick_cont(second_vec_q, gc, wide_q); // [RULE11]
            assign col_act = pick_act(second_pred_q, gc, wide_q); // [RULE5]

            dot4_lane u_lane (
                .a_in(row_cont),
                .b_in(col_cont),
                .a_act_in(row_act),
                .b_act_in(col_act),
                .wide_in(wide_q),
                .a_signed_in(a_signed),
                .sum_out(lane_sum[gc])
            );

            // Storage address: tile base plus row-major element offset
            always_comb begin
                int idx;
                idx = 0;
                if (wide_q) begin
                    idx = 2 * (int'(tile_q) * DWORD_ELEMS * DWORD_ELEMS
                               + int'(row_q) * DWORD_ELEMS + gc);
                end else begin
                    idx = int'(tile_q) * WORD_ELEMS * WORD_ELEMS
                          + int'(row_q) * WORD_ELEMS + gc;
                end
                lane_addr[gc] = ADDR_W'(idx);
            end

            // Current element, narrow or wide view
            assign old_val = wide_q ? {store_q[lane_addr[gc] + ADDR_W'(1)], store_q[lane_addr[gc]]}
                                    : {{(WW-NW){1'b0}}, store_q[lane_addr[gc]]};

            // Modular add or subtract; carries past the element are dropped
            always_comb begin
                if (sub_op) begin
                    lane_new[gc] = old_val - lane_sum[gc]; // [RULE7]
                end else begin
                    lane_new[gc] = old_val + lane_sum[gc]; // [RULE8]
                end
            end

            // Wide tiles have fewer columns; surplus lanes stay quiet
            assign lane_wr[gc] = (state_q == ST_RUN) && (!wide_q || gc < DWORD_ELEMS);
        end
    endgenerate

    // Tile write-back, truncated to element width so sums wrap with no flag.
    // Reset clears the tiles: accumulating into unknown words would stay unknown.
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            for (int w = 0; w < STORE_WORDS; w++) begin
                store_q[w] <= '0;
            end
        end else begin
            for (int c = 0; c < WORD_ELEMS; c++) begin
                if (lane_wr[c]) begin
                    store_q[lane_addr[c]] <= lane_new[c][NW-1:0]; // [RULE1] [RULE18]
                    if (wide_q) begin
                        store_q[lane_addr[c] + ADDR_W'(1)] <= lane_new[c][WW-1:NW]; // [RULE2]
                    end
                end
            end
        end
    end

    // Completion pulse after the last row is written
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_RUN) && last_row;
        end
    end

    // Refusal pulses; undefined encoding is checked before the enables.
    // Only control inputs decide them, never operand data or flags.
    always_ff @(posedge MCLK_IN) begin // [RULE16]
        if (!RST_N_IN) begin
            trap_q <= 1'b0;
            undef_q <= 1'b0;
        end else begin
            undef_q <= OP_VALID_IN && OP_READY_OUT
                       && OP_WIDE_IN && !WIDE_INT_VARIANT_PRESENT_IN; // [RULE13]
            trap_q <= OP_VALID_IN && OP_READY_OUT && !enabled
                      && !(OP_WIDE_IN && !WIDE_INT_VARIANT_PRESENT_IN); // [RULE19]
        end
    end

    // Registered read port for inspecting the tiles
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= store_q[RD_ADDR_IN];
        end
    end

    assign RD_DATA_OUT = rd_data_q;
    assign BUSY_OUT = (state_q == ST_RUN);
    assign DONE_OUT = done_q;
    assign TRAP_OUT = trap_q;
    assign UNDEF_OUT = undef_q;

endmodule

/* sim/opa_monitor.sv */
/*
 Checker for request taking, run length and pulse outputs.
 Assumes a bind to the datapath top, seeing its ports only.
*/
`timescale 1ns/1ns
module opa_monitor (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic OP_VALID_IN,
    input wire logic OP_READY_OUT,
    input wire logic OP_WIDE_IN,
    input wire logic STREAMING_EN_IN,
    input wire logic STORAGE_EN_IN,
    input wire logic WIDE_INT_VARIANT_PRESENT_IN,
    input wire logic BUSY_OUT,
    input wire logic DONE_OUT,
    input wire logic TRAP_OUT,
    input wire logic UNDEF_OUT
);
    logic ask;
    logic bad;
    logic off;
    logic go;
    // Request classes; a missing wide feature outranks disabled modes
    assign ask = OP_VALID_IN && OP_READY_OUT;
    assign bad = OP_WIDE_IN && !WIDE_INT_VARIANT_PRESENT_IN;
    assign off = !(STREAMING_EN_IN && STORAGE_EN_IN);
    assign go = ask && !bad && !off;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Run length is fixed by the variant alone, never by data or flags
    a_narrow_run: assert property (go && !OP_WIDE_IN |=>
        BUSY_OUT[*4] ##1 (DONE_OUT && !BUSY_OUT)) else $error("narrow run length wrong");
    a_wide_run: assert property (go && OP_WIDE_IN |=>
        BUSY_OUT[*2] ##1 (DONE_OUT && !BUSY_OUT)) else $error("wide run length wrong");
    a_undef_pulse: assert property (ask && bad |=>
        UNDEF_OUT && !TRAP_OUT && !BUSY_OUT) else $error("undefined pulse wrong");
    a_trap_pulse: assert property (ask && off && !bad |=>
        TRAP_OUT && !UNDEF_OUT && !BUSY_OUT) else $error("trap pulse wrong");
    a_ready_busy: assert property (OP_READY_OUT != BUSY_OUT)
        else $error("ready and busy agree");
    a_run_cause: assert property ($rose(BUSY_OUT) |-> $past(go))
        else $error("run without legal request");
    a_done_once: assert property (DONE_OUT |=> !DONE_OUT)
        else $error("done longer than one cycle");
    a_quiet_idle: assert property (!ask |=> !TRAP_OUT && !UNDEF_OUT)
        else $error("pulse without request");
    a_pulse_excl: assert property (TRAP_OUT || UNDEF_OUT |-> !DONE_OUT)
        else $error("fault pulse with done");
endmodule

bind int_outer_product_accumulate opa_monitor mon (.MCLK_IN, .RST_N_IN, .OP_VALID_IN,
    .OP_READY_OUT, .OP_WIDE_IN, .STREAMING_EN_IN, .STORAGE_EN_IN,
    .WIDE_INT_VARIANT_PRESENT_IN, .BUSY_OUT, .DONE_OUT, .TRAP_OUT, .UNDEF_OUT);

/* sim/opa_pipe_model.sv */
/*
 Pipeline-side model: presents one request, holds it until taken, then releases.
 Assumes its tasks are called at a falling edge of the core clock.
*/
`timescale 1ns/1ns
module opa_pipe_model
    import opa_pkg::*;
(
    input wire logic mclk_in,
    input wire logic ready_in,
    output logic valid_out,
    output op_kind_t kind_out,
    output logic wide_out,
    output logic [2:0] tile_out,
    output logic [127:0] a_out,
    output logic [127:0] b_out,
    output logic [15:0] pa_out,
    output logic [15:0] pb_out,
    output logic [3:0] flags_out,
    output logic [2:0] en_out
);
    // Quiet request lines from time zero
    initial begin
        valid_out = 1'b0;
        kind_out = mixed_sign_outer_acc;
        wide_out = 1'b0;
        tile_out = 3'h0;
        a_out = 128'h0;
        b_out = 128'h0;
        pa_out = 16'h0;
        pb_out = 16'h0;
        flags_out = 4'h0;
        en_out = 3'h0;
    end

    // Hold everything until the edge where ready is seen high
    task automatic issue(input op_kind_t k, input logic w, input logic [2:0] t,
        input logic [3:0] f, input logic [2:0] en, input logic [127:0] a, b,
        input logic [15:0] p1, p2);
        int n;
        valid_out = 1'b1;
        kind_out = k;
        wide_out = w;
        tile_out = t;
        flags_out = f;
        en_out = en;
        a_out = a;
        b_out = b;
        pa_out = p1;
        pb_out = p2;
        n = 0;
        while (ready_in !== 1'b1 && n < 50) begin
            @(negedge mclk_in);
            n++;
        end
        @(posedge mclk_in);
    endtask

    // Released operands no longer show the last value, so flip them
    task automatic idle();
        valid_out = 1'b0;
        a_out = ~a_out;
        b_out = ~b_out;
        pa_out = ~pa_out;
        pb_out = ~pb_out;
    endtask
endmodule

/* sim/int_outer_product_accumulate_test.sv */
/*
 Self-checking bench: run timing, tile results and refused requests.
 Assumes the pipeline model drives requests; tiles are read through the read port.
*/
`timescale 1ns/1ns
module int_outer_product_accumulate_test;
    import opa_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic valid, ready, wide, busy, done, trap, undef;
    op_kind_t kind;
    logic [2:0] tile, en;
    logic [3:0] flags;
    logic [127:0] va, vb, op_a, op_b;
    logic [15:0] pa, pb, op_pa, op_pb;
    logic [5:0] rd_addr = 6'h00;
    logic [31:0] rd_data;
    logic [31:0] old [16];
    int fail_count = 0;
    int compares = 0;

    // Core clock, 100 ns period
    initial begin
        forever #50 mclk = ~mclk;
    end

    opa_pipe_model pipe (.mclk_in(mclk), .ready_in(ready), .valid_out(valid),
        .kind_out(kind), .wide_out(wide), .tile_out(tile), .a_out(va), .b_out(vb),
        .pa_out(pa), .pb_out(pb), .flags_out(flags), .en_out(en));

    int_outer_product_accumulate dut (.MCLK_IN(mclk), .RST_N_IN(rst_n),
        .OP_VALID_IN(valid), .OP_READY_OUT(ready), .OP_KIND_IN(kind), .OP_WIDE_IN(wide),
        .DEST_TILE_FIELD_IN(tile), .FIRST_VECTOR_IN(va), .SECOND_VECTOR_IN(vb),
        .FIRST_PREDICATE_IN(pa), .SECOND_PREDICATE_IN(pb), .CONDITION_FLAGS_IN(flags),
        .STREAMING_EN_IN(en[2]), .STORAGE_EN_IN(en[1]), .WIDE_INT_VARIANT_PRESENT_IN(en[0]),
        .RD_ADDR_IN(rd_addr), .RD_DATA_OUT(rd_data), .BUSY_OUT(busy), .DONE_OUT(done),
        .TRAP_OUT(trap), .UNDEF_OUT(undef));

    task automatic check(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    // Read port answers one cycle after the address
    task automatic rd(input int a, output logic [31:0] d);
        @(negedge mclk);
        rd_addr = 6'(a);
        @(negedge mclk);
        d = rd_data;
    endtask

    // Reference 4-way dot product; second source is always unsigned
    function automatic logic [63:0] dot(op_kind_t k, logic w, int r, int c);
        logic [127:0] xa, yb;
        longint x, s;
        int sz, ia, ib;
        s = 0;
        sz = w ? 16 : 8;
        for (int j = 0; j < 4; j++) begin
            ia = 4 * r + j;
            ib = 4 * c + j;
            xa = op_a >> (sz * ia);
            yb = op_b >> (sz * ib);
            if (k inside {mixed_sign_outer_acc, mixed_sign_outer_sub})
                x = w ? $signed(xa[15:0]) : $signed(xa[7:0]);
            else
                x = w ? xa[15:0] : xa[7:0];
            if (op_pa[ia * sz / 8] && op_pb[ib * sz / 8])
                s += x * (w ? yb[15:0] : yb[7:0]);
        end
        return (k inside {mixed_sign_outer_sub, unsigned_outer_sub}) ? -s : s;
    endfunction

    // Issue reps back-to-back requests, check every cycle, then the whole tile
    task automatic run_op(input op_kind_t k, input logic w, input logic [2:0] t,
        input logic [3:0] f, input logic [2:0] e, input int reps);
        int n, dm, base;
        logic ue, ill, ok;
        logic [63:0] d;
        logic [31:0] lo, hi;
        ue = w && !e[0];
        ill = ue || !e[2] || !e[1];
        n = ill ? 0 : (w ? 2 : 4);
        dm = w ? 2 : 4;
        base = w ? 8 * t : 16 * t[1:0];
        for (int i = 0; i < 16 / (w ? 2 : 1); i++) rd(base + i, old[i]);
        for (int r = 0; r < reps; r++) begin
            pipe.issue(k, w, t, f, e, op_a, op_b, op_pa, op_pb);
            for (int c = 1; c <= n + 1; c++) begin
                @(negedge mclk);
                if (c == 1) pipe.idle();
                ok = busy === (c <= n) && done === (!ill && c > n);
                check(ok && trap === (ill && !ue) && undef === ue, "cycles");
            end
        end
        for (int i = 0; i < dm * dm; i++) begin
            d = ill ? 64'h0 : dot(k, w, i / dm, i % dm) * reps;
            if (w) begin
                rd(base + 2 * i, lo);
                rd(base + 2 * i + 1, hi);
                check({hi, lo} === {old[2*i+1], old[2*i]} + d, "wide elem");
            end else begin
                rd(base + i, lo);
                check(lo === old[i] + d[31:0], "narrow elem");
            end
        end
    endtask

    task automatic t_reset();
        check(ready === 1'b1 && busy === 1'b0 && done === 1'b0, "reset handshake");
        check(trap === 1'b0 && undef === 1'b0 && rd_data === 32'h0, "reset pulses");
    endtask

    // All kinds, signed edge bytes, sparse predicates, tile bit 2 set and ignored
    task automatic t_narrow();
        op_a = 128'h80ff017f_c3a55a3c_7f8001fe_ff001234;
        op_b = 128'hff807f01_00ffa5c3_12345678_fedcba98;
        op_pa = 16'hf7fe;
        op_pb = 16'hbfdf;
        for (int i = 0; i < 4; i++) begin
            run_op(op_kind_t'(i), 1'b0, 3'(i + 4), 4'(i * 5), 3'b111, i == 2 ? 2 : 1);
        end
    endtask

    // Wide kinds into tiles four to seven
    task automatic t_wide();
        op_pa = 16'hdbf5;
        for (int i = 0; i < 4; i++) begin
            run_op(op_kind_t'(i), 1'b1, 3'(i + 4), 4'(15 - i), 3'b111, 1);
        end
    endtask

    // Missing feature, disabled modes, both at once, and narrow without feature
    task automatic t_refuse();
        logic [3:0] cfg [5] = '{4'b1110, 4'b0011, 4'b0101, 4'b1010, 4'b0110};
        for (int i = 0; i < 5; i++) begin
            run_op(unsigned_outer_sub, cfg[i][3], 3'h6, 4'hf, cfg[i][2:0], 1);
        end
    endtask

    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_narrow();
        t_wide();
        t_refuse();
        conclude();
    end

    // A hang is cut off well past the expected run of about seven hundred cycles
    initial begin
        #500000;
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
